// file: remote_ctl_pkg.sv
// shared constants, types and register map of the remote control bank
package remote_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [15:0] REG_DISPLAY1 = 16'h0038;
  localparam logic [15:0] REG_DISPLAY4 = 16'h003b;
  localparam logic [15:0] REG_SETPOINT = 16'h0041;
  localparam logic [15:0] REG_OPERATION = 16'h0042;
  localparam logic [15:0] REG_SELECTOR = 16'h0043;

  // reset values
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;
  localparam logic [15:0] OPERATION_RESET = 16'h0000;
  localparam logic [15:0] SELECTOR_RESET = 16'h0000;
  localparam logic [15:0] DISPLAY_RESET = 16'h0000;

  // operation word bits
  localparam int OP_RUN_BIT = 0;
  localparam int OP_MODE_BIT = 1;
  localparam int OP_ALARM_BIT = 2;

  // selector fields
  localparam int SEL_W = 4;
  localparam int SEL_COUNT = 4;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_AMBIENT = 4'h1;
  localparam logic [3:0] SEL_EXT_TUNE = 4'h2;
  localparam logic [3:0] SEL_INLET = 4'h3;
  localparam logic [3:0] SEL_MAINT = 4'h4;
  localparam logic [3:0] SEL_PRESSURE = 4'h5;
  localparam logic [15:0] EXT_TUNE_OFF_VALUE = 16'hf334;

  ////////////////////////////////////////////////////////////////////////
  // link protocol
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_READ_INPUT = 8'h04;
  localparam logic [7:0] FN_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [3:0] RTU_FRAME_LEN = 4'd8;
  localparam logic [3:0] ASCII_FRAME_LEN = 4'd7;
  localparam logic [3:0] BUF_DEPTH = 4'd8;
  localparam logic [2:0] LEN_READ_REPLY = 3'd5;
  localparam logic [2:0] LEN_WRITE_REPLY = 3'd6;
  localparam logic [2:0] LEN_EXC_REPLY = 3'd3;

  typedef struct packed {
    logic [15:0] ambient;
    logic [15:0] ext_tune;
    logic ext_tune_on;
    logic [15:0] inlet;
    logic [15:0] maint;
    logic [15:0] pressure;
  } sensor_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_SEND = 3'b100
  } frame_state_e;

endpackage : remote_ctl_pkg

// file: crc16_step.sv
// one byte step of the reflected 16-bit link checksum
`timescale 1ns/1ps
module crc16_step
  import remote_ctl_pkg::*;
(
  input wire logic [15:0] crc_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] crc_o
);

  always_comb begin
    logic [15:0] c;
    c = crc_i ^ {8'h00, byte_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : crc16_step

// file: display_slot.sv
// one display word: selector chooses the shown quantity
`timescale 1ns/1ps
module display_slot
  import remote_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] sel_i,
  input wire sensor_s sensor_i,
  output logic [15:0] value_o
);

  logic [15:0] value_d;
  logic [15:0] value_q;

  // temperatures pass as signed tenths of a degree, unchanged
  always_comb begin
    case (sel_i)
      SEL_NONE: value_d = 16'h0000;
      SEL_AMBIENT: value_d = sensor_i.ambient;
      SEL_EXT_TUNE: begin
        value_d = sensor_i.ext_tune_on ? sensor_i.ext_tune : EXT_TUNE_OFF_VALUE;
      end
      SEL_INLET: value_d = sensor_i.inlet;
      SEL_MAINT: value_d = sensor_i.maint;
      SEL_PRESSURE: value_d = sensor_i.pressure;
      default: value_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      value_q <= DISPLAY_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

  chk_undefined_zero: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (sel_i > SEL_PRESSURE) |=> (value_q == 16'h0000))
    else $error("undefined selector did not read zero");

  chk_ext_tune_min: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (sel_i == SEL_EXT_TUNE && !sensor_i.ext_tune_on)
      |=> (value_q == EXT_TUNE_OFF_VALUE))
    else $error("external tuning off did not show minimum");

endmodule : display_slot

// file: remote_control_register_bank.sv
// serial-link holding registers, frame engine and display selection
`timescale 1ns/1ps
module remote_control_register_bank
  import remote_ctl_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic MODE_ASCII_I,
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_GAP_I,
  input wire logic TX_READY_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  input wire logic CONTACT_INPUT_RUN_CONTROL_SETTING_I,
  input wire logic PANEL_LOCAL_I,
  input wire logic [15:0] SP_MIN_I,
  input wire logic [15:0] SP_MAX_I,
  input wire sensor_s SENSOR_I,
  output logic [15:0] SETPOINT_O,
  output logic RUN_REQ_O,
  output logic SERIAL_MODE_O,
  output logic ALARM_CLEAR_O
);

  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : to_hex

  function automatic logic [4:0] from_hex(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    from_hex = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      d = c - 8'h30;
      from_hex = {1'b1, d[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      d = c - 8'h37;
      from_hex = {1'b1, d[3:0]};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      d = c - 8'h57;
      from_hex = {1'b1, d[3:0]};
    end
  endfunction : from_hex

  ////////////////////////////////////////////////////////////////////////
  // receive side
  frame_state_e state_q;
  logic [7:0] buf_q [0:7];
  logic [3:0] cnt_q;
  logic bad_q;
  logic frame_on_q;
  logic hi_have_q;
  logic [3:0] hi_nib_q;
  logic cr_q;
  logic [7:0] lrc_rx_q;
  logic [15:0] crc_rx_q;
  logic [15:0] crc_rx_d;
  logic rx_take;
  logic [4:0] hx;
  logic put;
  logic [7:0] put_byte;
  logic frame_ok;

  assign rx_take = RX_VALID_I && (state_q == ST_IDLE);
  assign hx = from_hex(RX_DATA_I);

  always_comb begin
    put = 1'b0;
    put_byte = RX_DATA_I;
    if (rx_take && !MODE_ASCII_I && !RX_GAP_I) begin
      put = 1'b1;
    end else if (rx_take && MODE_ASCII_I && frame_on_q && hx[4] &&
                 hi_have_q && !cr_q) begin
      put = 1'b1;
      put_byte = {hi_nib_q, hx[3:0]};
    end
  end

  // a whole frame is checked on its own end marker only
  always_comb begin
    frame_ok = 1'b0;
    if (MODE_ASCII_I) begin
      frame_ok = rx_take && RX_DATA_I == CH_LF && frame_on_q && cr_q &&
                 cnt_q == ASCII_FRAME_LEN && !bad_q && !hi_have_q &&
                 lrc_rx_q == 8'h00;
    end else if (state_q == ST_IDLE) begin
      frame_ok = RX_GAP_I && cnt_q == RTU_FRAME_LEN && !bad_q &&
                 crc_rx_q == 16'h0000;
    end
  end

  crc16_step u_crc_rx (
    .crc_i(crc_rx_q),
    .byte_i(put_byte),
    .crc_o(crc_rx_d)
  );

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      cnt_q <= 4'd0;
      bad_q <= 1'b0;
      frame_on_q <= 1'b0;
      hi_have_q <= 1'b0;
      hi_nib_q <= 4'h0;
      cr_q <= 1'b0;
      lrc_rx_q <= 8'h00;
      crc_rx_q <= CRC_INIT;
    end else if (MODE_ASCII_I) begin
      if (rx_take && RX_DATA_I == CH_COLON) begin
        frame_on_q <= 1'b1;
        cnt_q <= 4'd0;
        bad_q <= 1'b0;
        hi_have_q <= 1'b0;
        cr_q <= 1'b0;
        lrc_rx_q <= 8'h00;
      end else if (rx_take && frame_on_q) begin
        if (RX_DATA_I == CH_CR) begin
          cr_q <= 1'b1;
        end else if (RX_DATA_I == CH_LF) begin
          frame_on_q <= 1'b0;
          cr_q <= 1'b0;
        end else if (hx[4] && !cr_q) begin
          hi_have_q <= !hi_have_q;
          hi_nib_q <= hx[3:0];
        end else begin
          bad_q <= 1'b1;
        end
      end
    end else if (RX_GAP_I) begin
      cnt_q <= 4'd0;
      bad_q <= 1'b0;
      crc_rx_q <= CRC_INIT;
    end
    if (RESETN_I && put) begin
      if (cnt_q < BUF_DEPTH) begin
        cnt_q <= cnt_q + 4'd1;
      end else begin
        bad_q <= 1'b1; // overlong frame is dropped, not truncated
      end
      crc_rx_q <= crc_rx_d;
      lrc_rx_q <= lrc_rx_q + put_byte;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (put && cnt_q < BUF_DEPTH) begin
      buf_q[cnt_q[2:0]] <= put_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode, registers and side effects
  logic [15:0] reg_addr;
  logic [15:0] wr_val;
  logic is_read;
  logic is_write;
  logic [7:0] exc;
  logic [15:0] rd_data;
  logic wr_en;
  logic [15:0] setpoint_q;
  logic [15:0] op_q;
  logic [15:0] sel_q;
  logic serial_mode_q;
  logic run_q;
  logic alarm_clear_q;
  logic [15:0] disp [0:3];

  assign reg_addr = {buf_q[2], buf_q[3]};
  assign wr_val = {buf_q[4], buf_q[5]};
  assign is_read = buf_q[1] == FN_READ_HOLD || buf_q[1] == FN_READ_INPUT;
  assign is_write = buf_q[1] == FN_WRITE_SINGLE;

  always_comb begin
    logic [15:0] di;
    di = reg_addr - REG_DISPLAY1;
    rd_data = 16'h0000;
    exc = 8'h00;
    if (reg_addr >= REG_DISPLAY1 && reg_addr <= REG_DISPLAY4) begin
      rd_data = disp[di[1:0]];
    end else if (reg_addr == REG_SETPOINT) begin
      rd_data = setpoint_q;
    end else if (reg_addr == REG_OPERATION) begin
      rd_data = op_q;
    end else if (reg_addr == REG_SELECTOR) begin
      rd_data = sel_q;
    end else begin
      exc = EXC_ADDRESS;
    end
    if (!is_read && !is_write) begin
      exc = EXC_FUNCTION;
    end else if (is_read && wr_val != 16'h0001) begin
      exc = EXC_VALUE; // one register per read only
    end else if (is_write && reg_addr >= REG_DISPLAY1 &&
                 reg_addr <= REG_DISPLAY4) begin
      exc = EXC_ADDRESS;
    end
  end

  assign wr_en = (state_q == ST_EXEC) && is_write && exc == 8'h00;

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      setpoint_q <= SETPOINT_RESET;
    end else if (wr_en && reg_addr == REG_SETPOINT &&
                 serial_mode_q) begin
      if ($signed(wr_val) > $signed(SP_MAX_I)) begin
        setpoint_q <= SP_MAX_I;
      end else if ($signed(wr_val) < $signed(SP_MIN_I)) begin
        setpoint_q <= SP_MIN_I;
      end else begin
        setpoint_q <= wr_val;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      op_q <= OPERATION_RESET;
      sel_q <= SELECTOR_RESET;
    end else if (wr_en && reg_addr == REG_OPERATION) begin
      op_q <= wr_val;
    end else if (wr_en && reg_addr == REG_SELECTOR) begin
      sel_q <= wr_val;
    end
  end

  // the entry request wins over a panel return in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      serial_mode_q <= 1'b0;
    end else if (wr_en && reg_addr == REG_OPERATION &&
                 wr_val[OP_MODE_BIT] && !op_q[OP_MODE_BIT]) begin
      serial_mode_q <= 1'b1;
    end else if (PANEL_LOCAL_I) begin
      serial_mode_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      run_q <= 1'b0;
      alarm_clear_q <= 1'b0;
    end else begin
      alarm_clear_q <= wr_en && reg_addr == REG_OPERATION && serial_mode_q &&
                       wr_val[OP_ALARM_BIT] && !op_q[OP_ALARM_BIT];
      if (wr_en && reg_addr == REG_OPERATION && serial_mode_q &&
          !CONTACT_INPUT_RUN_CONTROL_SETTING_I) begin
        run_q <= wr_val[OP_RUN_BIT];
      end
    end
  end

  for (genvar g = 0; g < SEL_COUNT; g++) begin : g_slot
    display_slot u_slot (
      .clk_i(CLOCK_I),
      .resetn_i(RESETN_I),
      .sel_i(sel_q[g*SEL_W +: SEL_W]),
      .sensor_i(SENSOR_I),
      .value_o(disp[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // reply build and transmit
  logic [7:0] tx_buf_q [0:7];
  logic [2:0] tx_len_q;
  logic ascii_q;
  logic [4:0] tx_pos_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic [15:0] crc_tx_q;
  logic [15:0] crc_tx_d;
  logic [7:0] lrc_tx_q;
  logic [4:0] total;
  logic [4:0] pm1;
  logic [2:0] k;
  logic [7:0] byte_k;
  logic [7:0] char_d;
  logic load;
  logic last_lo;

  assign total = ascii_q ? ({1'b0, tx_len_q, 1'b0} + 5'd5)
                         : ({2'b00, tx_len_q} + 5'd2);
  assign pm1 = tx_pos_q - 5'd1;
  assign k = ascii_q ? pm1[3:1] : tx_pos_q[2:0];
  assign byte_k = (k < tx_len_q) ? tx_buf_q[k]
                : (ascii_q ? 8'h00 - lrc_tx_q : 8'h00);
  assign last_lo = pm1[0];
  assign load = state_q == ST_SEND && (!tx_valid_q || TX_READY_I) &&
                tx_pos_q < total;

  always_comb begin
    char_d = byte_k;
    if (ascii_q) begin
      if (tx_pos_q == 5'd0) begin
        char_d = CH_COLON;
      end else if (tx_pos_q == total - 5'd2) begin
        char_d = CH_CR;
      end else if (tx_pos_q == total - 5'd1) begin
        char_d = CH_LF;
      end else begin
        char_d = to_hex(last_lo ? byte_k[3:0] : byte_k[7:4]);
      end
    end else if (tx_pos_q == {2'b00, tx_len_q}) begin
      char_d = crc_tx_q[7:0];
    end else if (tx_pos_q == {2'b00, tx_len_q} + 5'd1) begin
      char_d = crc_tx_q[15:8];
    end
  end

  crc16_step u_crc_tx (
    .crc_i(crc_tx_q),
    .byte_i(byte_k),
    .crc_o(crc_tx_d)
  );

  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
      tx_len_q <= 3'd0;
      ascii_q <= 1'b0;
      tx_pos_q <= 5'd0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      crc_tx_q <= CRC_INIT;
      lrc_tx_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (frame_ok && (buf_q[0] == SLAVE_ADDR_I ||
                           buf_q[0] == ADDR_BROADCAST)) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // broadcast is acted on but never answered
          state_q <= (buf_q[0] == ADDR_BROADCAST) ? ST_IDLE : ST_SEND;
          ascii_q <= MODE_ASCII_I;
          tx_pos_q <= 5'd0;
          crc_tx_q <= CRC_INIT;
          lrc_tx_q <= 8'h00;
          tx_buf_q[0] <= buf_q[0];
          if (exc != 8'h00) begin
            tx_len_q <= LEN_EXC_REPLY;
            tx_buf_q[1] <= buf_q[1] | EXC_FLAG;
            tx_buf_q[2] <= exc;
          end else if (is_write) begin
            tx_len_q <= LEN_WRITE_REPLY;
            for (int i = 1; i < 6; i++) begin
              tx_buf_q[i] <= buf_q[i];
            end
          end else begin
            tx_len_q <= LEN_READ_REPLY;
            tx_buf_q[1] <= buf_q[1];
            tx_buf_q[2] <= 8'h02;
            tx_buf_q[3] <= rd_data[15:8];
            tx_buf_q[4] <= rd_data[7:0];
          end
        end
        ST_SEND: begin
          if (load) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= char_d;
            tx_pos_q <= tx_pos_q + 5'd1;
            if (!ascii_q && k < tx_len_q && tx_pos_q < {2'b00, tx_len_q}) begin
              crc_tx_q <= crc_tx_d;
            end
            if (ascii_q && last_lo && k < tx_len_q && tx_pos_q != 5'd0 &&
                tx_pos_q < total - 5'd2) begin
              lrc_tx_q <= lrc_tx_q + byte_k;
            end
          end else if (tx_pos_q >= total && (TX_READY_I || !tx_valid_q)) begin
            tx_valid_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign TX_VALID_O = tx_valid_q;
  assign TX_DATA_O = tx_data_q;
  assign SETPOINT_O = setpoint_q;
  assign RUN_REQ_O = run_q;
  assign SERIAL_MODE_O = serial_mode_q;
  assign ALARM_CLEAR_O = alarm_clear_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  chk_setpoint_gate: assert property (
    !serial_mode_q |=> setpoint_q == $past(setpoint_q))
    else $error("setpoint changed outside serial mode");
  chk_setpoint_high: assert property (
    (wr_en && reg_addr == REG_SETPOINT && serial_mode_q &&
     $signed(wr_val) > $signed(SP_MAX_I)) |=> setpoint_q == $past(SP_MAX_I))
    else $error("setpoint above range not clamped");
  chk_setpoint_low: assert property (
    (wr_en && reg_addr == REG_SETPOINT && serial_mode_q &&
     $signed(wr_val) <= $signed(SP_MAX_I) &&
     $signed(wr_val) < $signed(SP_MIN_I)) |=> setpoint_q == $past(SP_MIN_I))
    else $error("setpoint below range not clamped");
  chk_run_follow: assert property (
    (wr_en && reg_addr == REG_OPERATION && serial_mode_q &&
     !CONTACT_INPUT_RUN_CONTROL_SETTING_I) |=> RUN_REQ_O == $past(wr_val[0]))
    else $error("run request did not follow bit 0");
  chk_run_locked: assert property (
    CONTACT_INPUT_RUN_CONTROL_SETTING_I |=> RUN_REQ_O == $past(RUN_REQ_O))
    else $error("run request changed under contact control");
  chk_mode_enter: assert property (
    (wr_en && reg_addr == REG_OPERATION && wr_val[1] && !op_q[1])
      |=> SERIAL_MODE_O)
    else $error("mode request edge did not enter serial mode");
  chk_mode_hold: assert property (
    (SERIAL_MODE_O && !PANEL_LOCAL_I) |=> SERIAL_MODE_O)
    else $error("serial mode dropped without panel request");
  chk_alarm_pulse: assert property (
    (wr_en && reg_addr == REG_OPERATION && serial_mode_q && wr_val[2] &&
     !op_q[2]) |=> ALARM_CLEAR_O ##1 !ALARM_CLEAR_O)
    else $error("alarm clear pulse missing or too long");
  chk_write_echo: assert property (
    (wr_en && buf_q[0] != ADDR_BROADCAST) |=> state_q == ST_SEND &&
      tx_len_q == LEN_WRITE_REPLY && tx_buf_q[5] == $past(buf_q[5]))
    else $error("write reply is not an echo");
  chk_ascii_header: assert property (
    ($rose(TX_VALID_O) && ascii_q) |-> TX_DATA_O == CH_COLON)
    else $error("ascii reply does not open with a colon");

  cov_write_setpoint: cover property (
    wr_en && reg_addr == REG_SETPOINT && serial_mode_q);
  cov_ascii_reply: cover property ($fell(TX_VALID_O) && ascii_q);
  cov_rtu_reply: cover property ($fell(TX_VALID_O) && !ascii_q);
  cov_mode_enter: cover property ($rose(SERIAL_MODE_O));

endmodule : remote_control_register_bank

// file: modbus_host_model.sv
// serial host model: frames requests, collects replies
`timescale 1ns/1ps
module modbus_host_model
  import remote_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic mode_ascii_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_gap_o,
  output logic tx_ready_o
);
  logic [7:0] rsp[$];
  logic slow = 1'b0;
  logic hung = 1'b0;
  initial begin
    mode_ascii_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_gap_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc
  task automatic put(input logic [7:0] b);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    // released line never shows the stale byte
    rx_data_o = ~b;
  endtask : put
  task automatic gap();
    @(negedge clk_i);
    rx_gap_o = 1'b1;
    @(negedge clk_i);
    rx_gap_o = 1'b0;
  endtask : gap
  task automatic collect();
    logic seen;
    seen = 1'b0;
    rsp.delete();
    // settled values here are what the next rising edge accepts
    for (int n = 0; n < 80; n++) begin
      @(negedge clk_i);
      tx_ready_o = slow ? ~tx_ready_o : 1'b1;
      if (tx_valid_i === 1'b1 && tx_ready_o) rsp.push_back(tx_data_i);
      seen = seen | (tx_valid_i === 1'b1);
      if (seen && tx_valid_i === 1'b0) break;
    end
    if (tx_valid_i === 1'b1) hung = 1'b1;
    @(negedge clk_i);
    tx_ready_o = 1'b0;
  endtask : collect
  // binary fields, crc low byte first, then silence
  task automatic rtu(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc(b) ^ {15'h0000, bad};
    mode_ascii_o = 1'b0;
    foreach (b[i]) put(b[i]);
    put(c[7:0]);
    put(c[15:8]);
    gap();
    collect();
  endtask : rtu
  task automatic ascii(input string s);
    mode_ascii_o = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
    collect();
    mode_ascii_o = 1'b0;
  endtask : ascii
endmodule : modbus_host_model

// file: remote_control_register_bank_test.sv
// self-checking bench of the remote control register bank
`timescale 1ns/1ps
module remote_control_register_bank_test;
  import remote_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic contact = 1'b0;
  logic panel = 1'b0;
  logic [15:0] spmin = 16'hfff0;
  logic [15:0] spmax = 16'h0100;
  sensor_s sen = '0;
  logic ma, rv, rg, tr, tv, run, ser, alc;
  logic [7:0] rd_b, td;
  logic [15:0] sp;
  int error_cnt = 0;
  int checks_done = 0;
  int pulses = 0;
  initial forever #2.5 clk = ~clk;
  always @(negedge clk) if (alc === 1'b1) pulses++;
  remote_control_register_bank uut (
    .CLOCK_I(clk),
    .RESETN_I(rst_n),
    .MODE_ASCII_I(ma),
    .SLAVE_ADDR_I(8'h01),
    .RX_VALID_I(rv),
    .RX_DATA_I(rd_b),
    .RX_GAP_I(rg),
    .TX_READY_I(tr),
    .TX_VALID_O(tv),
    .TX_DATA_O(td),
    .CONTACT_INPUT_RUN_CONTROL_SETTING_I(contact),
    .PANEL_LOCAL_I(panel),
    .SP_MIN_I(spmin),
    .SP_MAX_I(spmax),
    .SENSOR_I(sen),
    .SETPOINT_O(sp),
    .RUN_REQ_O(run),
    .SERIAL_MODE_O(ser),
    .ALARM_CLEAR_O(alc)
  );
  modbus_host_model host (
    .clk_i(clk),
    .tx_valid_i(tv),
    .tx_data_i(td),
    .mode_ascii_o(ma),
    .rx_valid_o(rv),
    .rx_data_o(rd_b),
    .rx_gap_o(rg),
    .tx_ready_o(tr)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run();
    // a reply that never ended counts as a mismatch
    chk(16'(host.hung), 16'h0000);
    $display("mismatches %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    host.rtu({8'h01, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]}, 1'b0);
    chk(16'(host.rsp.size()), 16'd8);
    chk({host.rsp[2], host.rsp[3]}, a);
    chk({host.rsp[4], host.rsp[5]}, v);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    host.rtu({8'h01, 8'h04, a[15:8], a[7:0], 8'h00, 8'h01}, 1'b0);
    chk({host.rsp[3], host.rsp[4]}, e);
  endtask : rd
  task automatic t_local();
    chk({12'h000, run, ser, alc, tv}, 16'h0000);
    chk(sp, SETPOINT_RESET);
    wr(REG_SETPOINT, 16'h0050);
    chk(sp, 16'h0000);
    wr(REG_OPERATION, 16'h0003);
    chk({14'h0000, ser, run}, 16'h0002);
    wr(REG_OPERATION, 16'h0000);
    chk({15'h0000, ser}, 16'h0001);
  endtask : t_local
  task automatic t_clamp();
    logic [15:0] w[4] = '{16'h0200, 16'h0100, 16'hff00, 16'h0050};
    logic [15:0] x[4] = '{16'h0100, 16'h0100, 16'hfff0, 16'h0050};
    for (int i = 0; i < 4; i++) begin
      wr(REG_SETPOINT, w[i]);
      chk(sp, x[i]);
    end
  endtask : t_clamp
  task automatic t_opword();
    wr(REG_OPERATION, 16'h0001);
    chk({15'h0000, run}, 16'h0001);
    contact = 1'b1;
    wr(REG_OPERATION, 16'h0000);
    chk({15'h0000, run}, 16'h0001);
    contact = 1'b0;
    pulses = 0;
    wr(REG_OPERATION, 16'hfff8);
    chk({14'h0000, run, ser}, 16'h0001);
    chk(16'(pulses), 16'h0000);
    wr(REG_OPERATION, 16'h0004);
    chk(16'(pulses), 16'h0001);
    wr(REG_OPERATION, 16'h0004);
    chk(16'(pulses), 16'h0001);
  endtask : t_opword
  task automatic t_display();
    logic [15:0] e[4] = '{16'h00fa, 16'hf334, 16'h0005, 16'h0ccc};
    logic [15:0] f[4] = '{16'hff38, 16'h1234, 16'h00fa, 16'h0000};
    sen = '{16'h00fa, 16'h1234, 1'b0, 16'hff38, 16'h0005, 16'h0ccc};
    wr(REG_SELECTOR, 16'h0001);
    chk({host.rsp[6], host.rsp[7]}, 16'hb9de);
    wr(REG_SELECTOR, 16'h5421);
    for (int i = 0; i < 4; i++) rd(REG_DISPLAY1 + 16'(i), e[i]);
    sen.ext_tune_on = 1'b1;
    wr(REG_SELECTOR, 16'h6123);
    for (int i = 0; i < 4; i++) rd(REG_DISPLAY1 + 16'(i), f[i]);
  endtask : t_display
  task automatic t_ascii();
    string s = ":010600430001B5\r\n";
    // stalled receiver: every other cycle not ready
    host.slow = 1'b1;
    host.ascii(s);
    host.slow = 1'b0;
    chk(16'(host.rsp.size()), 16'd17);
    for (int i = 0; i < 17; i++) begin
      chk({8'h00, host.rsp[i]}, {8'h00, s[i]});
    end
  endtask : t_ascii
  task automatic t_refuse();
    // back in rtu framing: silence first, so only the checksum refuses
    host.gap();
    host.rtu({8'h01, 8'h06, 8'h00, 8'h41, 8'h00, 8'h30}, 1'b1);
    chk(16'(host.rsp.size()), 16'd0);
    chk(sp, 16'h0050);
    panel = 1'b1;
    @(negedge clk);
    panel = 1'b0;
    chk({15'h0000, ser}, 16'h0000);
    wr(REG_SETPOINT, 16'h0020);
    chk(sp, 16'h0050);
  endtask : t_refuse
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({12'h000, run, ser, alc, tv}, 16'h0000);
    chk(sp, SETPOINT_RESET);
    host.gap();
    rd(REG_DISPLAY1, 16'h0000);
    host.rtu({8'h01, FN_READ_HOLD, 8'h00, 8'h43, 8'h00, 8'h01}, 1'b0);
    chk({host.rsp[3], host.rsp[4]}, SELECTOR_RESET);
    host.rtu({8'h01, 8'h06, 8'h00, 8'h38, 8'h00, 8'h01}, 1'b0);
    chk(16'(host.rsp.size()), 16'd5);
    chk({host.rsp[1], host.rsp[2]}, {8'h86, EXC_ADDRESS});
  endtask : t_reset
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    // reset already clears the rtu frame state; this silence only repeats it before the first frame
    host.gap();
    t_local();
    t_clamp();
    t_opword();
    t_display();
    t_ascii();
    t_refuse();
    t_reset();
    complete_run();
  end
endmodule : remote_control_register_bank_test
